//--- design/osd_effects_i2c_port.sv
// Device end: two-wire register slave on the link clock and character effects on the system clock.
`timescale 1ns/1ps
`include "osd_effects_regs.svh"
module osd_effects_i2c_port #(
  parameter int POS_W = 10
) (
  // System clock domain
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // Link clock domain
  input  wire logic                        link_clk,
  osd_link_if.device                       lnk,
  // Scan and window state
  input  wire logic                        frame_start,
  input  wire logic                        win1_on,
  input  wire logic [POS_W-1:0]            win1_width,
  input  wire logic [POS_W-1:0]            win1_height,
  input  wire logic                        transp_line,
  input  wire logic [5:0]                  blink_frames,
  // Pixel from the character generator
  input  wire logic                        pix_valid,
  input  wire logic                        pix_win2,
  input  wire logic [POS_W-1:0]            pix_x,
  input  wire logic [POS_W-1:0]            pix_y,
  input  wire osd_effects_pkg::color_t     pix_color,
  input  wire osd_effects_pkg::color_t     pix_bg,
  input  wire logic [3:0]                  pix_attr,
  input  wire logic                        pix_two_color,
  input  wire logic                        pix_fg,
  input  wire logic [7:0]                  pix_nbr,
  input  wire logic                        pix_box_top,
  input  wire logic                        pix_box_left,
  input  wire logic                        pix_box_raised,
  input  wire logic                        pix_box_depressed,
  input  wire logic                        pix_box_heavy,
  input  wire logic                        pix_shadow_en,
  input  wire logic                        pix_border_en,
  input  wire logic                        pix_blink_en,
  // Effect output
  output logic                             osd_valid,
  output logic                             osd_show,
  output osd_effects_pkg::color_t          osd_rgb,
  output logic                             video_half
);
  import osd_effects_pkg::*;

  // Returns {hit, byte index}; index 0 frame control, 1-6 palettes, 7 fade interval.
  function automatic logic [3:0] map_addr(input logic [15:0] a);
    case (a)
      `FRAME_CONTROL_ADDR:              map_addr = 4'h8;
      `HIGHLIGHT_ADDR:                  map_addr = 4'h9;
      `HIGHLIGHT_ADDR + 16'h0001:       map_addr = 4'ha;
      `LOWLIGHT_ADDR:                   map_addr = 4'hb;
      `LOWLIGHT_ADDR + 16'h0001:        map_addr = 4'hc;
      `SHADOW_BORDER_ADDR:              map_addr = 4'hd;
      `SHADOW_BORDER_ADDR + 16'h0001:   map_addr = 4'he;
      `FADE_INTERVAL_ADDR:              map_addr = 4'hf;
      default:                          map_addr = 4'h0;
    endcase
  endfunction : map_addr

  // ------------------------------------------------------------
  // Link side
  // ------------------------------------------------------------
  link_state_t lstate;
  logic        rst_meta;
  logic        link_rst;
  logic        scl_meta;
  logic        scl_s;
  logic        scl_d;
  logic        sda_meta;
  logic        sda_s;
  logic        sda_d;
  logic [3:0]  bcnt;
  logic [1:0]  idx;
  logic        rw;
  logic        mack_ok;
  byte_t       shreg;
  logic [15:0] reg_addr;
  reg_bank_t   bank;
  logic        wr_tog;
  logic [3:0]  sel;
  byte_t       rd_byte;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_cond;
  logic        stop_cond;
  logic        byte_done;
  logic        tx_load;

  assign lnk.dev_scl_o  = 1'b0;
  assign lnk.dev_scl_oe = 1'b0;
  assign lnk.dev_sda_o  = 1'b0;

  always_ff @(posedge link_clk) begin
    rst_meta <= sys_rst;
    link_rst <= rst_meta;
  end

  always_ff @(posedge link_clk) begin
    scl_meta <= lnk.scl;
    scl_s    <= scl_meta;
    scl_d    <= scl_s;
    sda_meta <= lnk.sda;
    sda_s    <= sda_meta;
    sda_d    <= sda_s;
  end

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  assign byte_done  = (lstate == L_RECV) && scl_fall && (bcnt == 4'd8);
  assign tx_load    = scl_fall && (((lstate == L_ACK) && rw) || ((lstate == L_MACK) && mack_ok));
  assign sel        = map_addr(reg_addr);
  assign rd_byte    = sel[3] ? bank[sel[2:0]] : `UNMAPPED_READ;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lstate         <= L_IDLE;
      bcnt           <= 4'h0;
      idx            <= 2'h0;
      rw             <= 1'b0;
      mack_ok        <= 1'b0;
      shreg          <= 8'h00;
      lnk.dev_sda_oe <= 1'b0;
    end else if (start_cond) begin
      lstate         <= L_RECV;
      bcnt           <= 4'h0;
      idx            <= 2'h0;
      lnk.dev_sda_oe <= 1'b0;
    end else if (stop_cond) begin
      lstate         <= L_IDLE;
      lnk.dev_sda_oe <= 1'b0;
    end else begin
      case (lstate)
        L_RECV: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bcnt  <= bcnt + 4'h1;
          end else if (byte_done) begin
            if (idx == 2'h0) begin
              rw <= shreg[0];
            end
            if (idx == 2'h0 && shreg[7:1] != `SLAVE_ADDR) begin
              lstate <= L_IDLE;
            end else begin
              lstate         <= L_ACK;
              lnk.dev_sda_oe <= 1'b1;
              if (idx != 2'h3) begin
                idx <= idx + 2'h1;
              end
            end
          end
        end
        L_ACK: begin
          if (scl_fall) begin
            lnk.dev_sda_oe <= 1'b0;
            bcnt           <= 4'h0;
            lstate         <= L_RECV;
          end
        end
        L_SEND: begin
          if (scl_fall) begin
            if (bcnt == 4'd8) begin
              lnk.dev_sda_oe <= 1'b0;
              mack_ok        <= 1'b0;
              lstate         <= L_MACK;
            end else begin
              lnk.dev_sda_oe <= ~shreg[6];
              shreg          <= {shreg[6:0], 1'b0};
              bcnt           <= bcnt + 4'h1;
            end
          end
        end
        L_MACK: begin
          if (scl_rise) begin
            mack_ok <= ~sda_s;
          end else if (scl_fall) begin
            lstate <= L_IDLE;
          end
        end
        default: begin
          lstate <= L_IDLE;
        end
      endcase
      // A read byte is loaded after the address ack or after each master ack.
      if (tx_load) begin
        shreg          <= rd_byte;
        lnk.dev_sda_oe <= ~rd_byte[7];
        bcnt           <= 4'h1;
        lstate         <= L_SEND;
      end
    end
  end

  // The address survives a stop so that a read resumes where the address-only write left it.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      reg_addr <= 16'h0000;
    end else if (byte_done && idx == 2'h1) begin
      reg_addr[7:0] <= shreg;
    end else if (byte_done && idx == 2'h2) begin
      reg_addr[15:8] <= shreg;
    end else if ((byte_done && idx == 2'h3) || tx_load) begin
      reg_addr <= reg_addr + 16'h0001;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      bank   <= {8{`REG_RESET}};
      wr_tog <= 1'b0;
    end else if (byte_done && idx == 2'h3 && sel[3]) begin
      bank[sel[2:0]] <= shreg;
      wr_tog         <= ~wr_tog;
    end
  end

  // ------------------------------------------------------------
  // Pixel side
  // ------------------------------------------------------------
  // The bank holds still for at least nine link bit times after each write,
  // so one toggle handshake is enough to copy the whole bank.
  logic             tog_meta;
  logic             tog_s;
  logic             tog_d;
  reg_bank_t        cfg;
  logic [POS_W-1:0] ext_x;
  logic [POS_W-1:0] ext_y;
  logic [5:0]       blink_cnt;
  logic             blink_phase;
  logic             half_tone;
  logic             fade_en;
  logic [3:0]       h_step;
  logic [3:0]       v_step;
  color_t           highlight;
  color_t           lowlight;
  color_t           shade;
  color_t           col;
  logic             is_box;
  logic             bg_pix;
  logic             see_through;
  logic             in_fade;

  always_ff @(posedge clock) begin
    tog_meta <= wr_tog;
    tog_s    <= tog_meta;
    tog_d    <= tog_s;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfg <= {8{`REG_RESET}};
    end else if (tog_s ^ tog_d) begin
      cfg <= bank;
    end
  end

  assign half_tone = cfg[0][`HALF_TONE_BIT];
  assign fade_en   = cfg[0][`FADE_EN_BIT];
  assign h_step    = cfg[7][7:4];
  assign v_step    = cfg[7][3:0];
  assign highlight = {cfg[2][0], cfg[1]};
  assign lowlight  = {cfg[4][0], cfg[3]};
  assign shade     = {cfg[6][0], cfg[5]};

  // A zero step pins that direction to the full extent.
  function automatic logic [POS_W-1:0] fade_step(input logic [POS_W-1:0] cur, input logic [POS_W-1:0] lim,
                                                 input logic [3:0] step, input logic grow);
    logic [POS_W:0] sum;
    sum = {1'b0, cur} + {{(POS_W-3){1'b0}}, step};
    if (step == 4'h0) begin
      fade_step = lim;
    end else if (grow) begin
      fade_step = (sum > {1'b0, lim}) ? lim : sum[POS_W-1:0];
    end else begin
      fade_step = (cur > POS_W'(step)) ? cur - POS_W'(step) : '0;
    end
  endfunction : fade_step

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_x <= '0;
      ext_y <= '0;
    end else if (frame_start) begin
      if (!fade_en) begin
        ext_x <= win1_on ? win1_width : '0;
        ext_y <= win1_on ? win1_height : '0;
      end else begin
        ext_x <= fade_step(ext_x, win1_width, h_step, win1_on);
        ext_y <= fade_step(ext_y, win1_height, v_step, win1_on);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      blink_cnt   <= 6'h00;
      blink_phase <= 1'b0;
    end else if (frame_start) begin
      if (blink_cnt == blink_frames) begin
        blink_cnt   <= 6'h00;
        blink_phase <= ~blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 6'h01;
      end
    end
  end

  always_comb begin
    is_box = (pix_box_top | pix_box_left) & (pix_box_raised | pix_box_depressed);
    bg_pix = pix_two_color & ~pix_fg;
    col    = pix_color;
    if (bg_pix && pix_border_en && |pix_nbr) begin
      col = shade;
    end else if (bg_pix && pix_shadow_en && |{pix_nbr[3], pix_nbr[1:0]}) begin
      col = shade;
    end
    if (pix_blink_en && blink_phase) begin
      col = pix_bg;
    end
    if (is_box) begin
      col = pix_box_raised ? highlight : (pix_box_heavy ? shade : lowlight);
    end
    see_through = transp_line & ~pix_attr[3] & (col == `BLACK_CODE);
    in_fade     = pix_win2 | ((pix_x < ext_x) && (pix_y < ext_y));
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      osd_valid  <= 1'b0;
      osd_show   <= 1'b0;
      osd_rgb    <= `BLACK_CODE;
      video_half <= 1'b0;
    end else begin
      osd_valid  <= pix_valid;
      osd_show   <= pix_valid & in_fade & ~see_through;
      osd_rgb    <= col;
      video_half <= pix_valid & in_fade & see_through & half_tone;
    end
  end
endmodule : osd_effects_i2c_port

//--- design/osd_effects_regs.svh
// Register offsets, field positions, reset values and timing counts of the OSD effects port.
`ifndef OSD_EFFECTS_REGS_SVH
`define OSD_EFFECTS_REGS_SVH
`define FRAME_CONTROL_ADDR 16'h8400
`define HIGHLIGHT_ADDR     16'h8405
`define LOWLIGHT_ADDR      16'h8407
`define SHADOW_BORDER_ADDR 16'h8409
`define FADE_INTERVAL_ADDR 16'h8429
`define HALF_TONE_BIT      7
`define FADE_EN_BIT        5
`define REG_RESET          8'h00
`define UNMAPPED_READ      8'h00
`define SLAVE_ADDR         7'h5d
`define WRITE_ADDR_BYTE    {`SLAVE_ADDR, 1'b0}
`define READ_ADDR_BYTE     {`SLAVE_ADDR, 1'b1}
`define BLACK_CODE         9'h000
`define CLK_PERIOD_PS      8000
`define SCL_PERIOD_PS      10000000
`define SCL_QUARTER_CYC    ((`SCL_PERIOD_PS + 4 * `CLK_PERIOD_PS - 1) / (4 * `CLK_PERIOD_PS))
`endif

//--- design/osd_effects_pkg.sv
// Types shared by both ends of the OSD effects port.
package osd_effects_pkg;
  typedef logic [7:0]      byte_t;
  typedef logic [8:0]      color_t;
  typedef logic [7:0][7:0] reg_bank_t;
  typedef enum {L_IDLE, L_RECV, L_ACK, L_SEND, L_MACK} link_state_t;
  typedef enum {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
endpackage : osd_effects_pkg

//--- design/osd_link_if.sv
// Two-wire link between the microcontroller end and the OSD device end.
`timescale 1ns/1ps
interface osd_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires: a line is low while any enabled driver pulls it low.
  assign scl = ~((host_scl_oe & ~host_scl_o) | (dev_scl_oe & ~dev_scl_o));
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (input scl, input sda, output dev_scl_o, output dev_scl_oe, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface : osd_link_if

//--- design/osd_link_master.sv
// Microcontroller end: two-wire master that writes or reads one register byte per command.
`timescale 1ns/1ps
`include "osd_effects_regs.svh"
module osd_link_master #(
  parameter int QUARTER_CYC = `SCL_QUARTER_CYC
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // Command
  input  wire logic                     cmd_valid,
  input  wire logic                     cmd_read,
  input  wire logic [15:0]              cmd_addr,
  input  wire osd_effects_pkg::byte_t   cmd_wdata,
  output logic                          cmd_ready,
  // Response
  output logic                          rsp_valid,
  output osd_effects_pkg::byte_t        rsp_rdata,
  output logic                          rsp_err,
  // Link
  osd_link_if.host                      lnk
);
  import osd_effects_pkg::*;

  host_state_t state;
  logic [15:0] q_cnt;
  logic        tick;
  logic [1:0]  ph;
  logic [3:0]  bit_i;
  logic [1:0]  byte_n;
  logic        second;
  logic        rd;
  logic        err;
  logic [15:0] addr;
  byte_t       wdata;
  byte_t       shreg;
  logic        sda_meta;
  logic        sda_s;
  logic        rx;
  logic        last;

  // Byte n of the first or the second transfer of a command.
  function automatic byte_t next_byte(input logic sec, input logic [1:0] n, input logic [15:0] a, input byte_t d);
    if (sec) begin
      next_byte = `READ_ADDR_BYTE;
    end else begin
      case (n)
        2'h0:    next_byte = `WRITE_ADDR_BYTE;
        2'h1:    next_byte = a[7:0];
        2'h2:    next_byte = a[15:8];
        default: next_byte = d;
      endcase
    end
  endfunction : next_byte

  assign lnk.host_scl_o = 1'b0;
  assign lnk.host_sda_o = 1'b0;
  assign tick = (q_cnt == 16'(QUARTER_CYC - 1));
  assign rx   = second && (byte_n == 2'h1);
  // A read command sends only the address in its first transfer.
  assign last = (byte_n == (second ? 2'h1 : (rd ? 2'h2 : 2'h3)));

  always_ff @(posedge clock) begin
    sda_meta <= lnk.sda;
    sda_s    <= sda_meta;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || state == H_IDLE || tick) begin
      q_cnt <= 16'h0000;
    end else begin
      q_cnt <= q_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state           <= H_IDLE;
      ph              <= 2'h0;
      bit_i           <= 4'h0;
      byte_n          <= 2'h0;
      second          <= 1'b0;
      rd              <= 1'b0;
      err             <= 1'b0;
      addr            <= 16'h0000;
      wdata           <= 8'h00;
      shreg           <= 8'h00;
      cmd_ready       <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_rdata       <= 8'h00;
      rsp_err         <= 1'b0;
      lnk.host_scl_oe <= 1'b0;
      lnk.host_sda_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            rd        <= cmd_read;
            addr      <= cmd_addr;
            wdata     <= cmd_wdata;
            second    <= 1'b0;
            err       <= 1'b0;
            byte_n    <= 2'h0;
            ph        <= 2'h0;
            state     <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: begin
                lnk.host_scl_oe <= 1'b0;
                lnk.host_sda_oe <= 1'b0;
              end
              2'h1: lnk.host_sda_oe <= 1'b1;
              2'h2: lnk.host_scl_oe <= 1'b1;
              default: begin
                shreg <= next_byte(second, 2'h0, addr, wdata);
                bit_i <= 4'h0;
                state <= H_BIT;
              end
            endcase
          end
        end
        H_BIT: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: begin
                lnk.host_scl_oe <= 1'b1;
                lnk.host_sda_oe <= (bit_i != 4'd8) && !rx && !shreg[7];
              end
              2'h1: lnk.host_scl_oe <= 1'b0;
              2'h2: begin
                if (bit_i != 4'd8) begin
                  shreg <= {shreg[6:0], sda_s};
                end else if (!rx && sda_s) begin
                  err <= 1'b1;
                end
              end
              default: begin
                lnk.host_scl_oe <= 1'b1;
                if (bit_i != 4'd8) begin
                  bit_i <= bit_i + 4'h1;
                end else begin
                  if (rx) begin
                    rsp_rdata <= shreg;
                  end
                  if (last || err) begin
                    state <= H_STOP;
                  end else begin
                    byte_n <= byte_n + 2'h1;
                    shreg  <= next_byte(second, byte_n + 2'h1, addr, wdata);
                    bit_i  <= 4'h0;
                  end
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph <= ph + 2'h1;
            case (ph)
              2'h0: begin
                lnk.host_scl_oe <= 1'b1;
                lnk.host_sda_oe <= 1'b1;
              end
              2'h1: lnk.host_scl_oe <= 1'b0;
              2'h2: lnk.host_sda_oe <= 1'b0;
              default: begin
                if (rd && !second && !err) begin
                  second <= 1'b1;
                  byte_n <= 2'h0;
                  state  <= H_START;
                end else begin
                  rsp_valid <= 1'b1;
                  rsp_err   <= err;
                  state     <= H_IDLE;
                end
              end
            endcase
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule : osd_link_master

//--- verif/osd_link_checker.sv
// Checker for open-drain levels and acknowledge timing on the two-wire link.
`timescale 1ns/1ps
module osd_link_checker (
  // Clocks and reset
  input logic clock,
  input logic sys_rst,
  input logic link_clk,
  // Link signals
  input logic host_scl_o,
  input logic host_scl_oe,
  input logic host_sda_o,
  input logic host_sda_oe,
  input logic dev_sda_o,
  input logic dev_sda_oe,
  input logic scl,
  input logic sda
);
  a_ack_scl_low: assert property (
    @(posedge link_clk) disable iff (sys_rst) $rose(dev_sda_oe) |-> !scl) else $error("pull began with SCL high");
  a_ack_steady_high: assert property (
    @(posedge link_clk) disable iff (sys_rst) scl && $past(scl) |-> $stable(dev_sda_oe)) else $error("SDA moved");
  a_ack_release: assert property (
    @(posedge link_clk) disable iff (sys_rst) $rose(dev_sda_oe) |-> ##[1:300] !dev_sda_oe) else $error("SDA stuck");
  a_no_sda_fight: assert property (
    @(posedge link_clk) disable iff (sys_rst) scl |-> !(dev_sda_oe && host_sda_oe)) else $error("both drive SDA");
  a_scl_from_host: assert property (
    @(posedge clock) disable iff (sys_rst) scl == !host_scl_oe) else $error("SCL level wrong");
  a_drain_only: assert property (
    @(posedge clock) disable iff (sys_rst) !host_sda_o && !host_scl_o && !dev_sda_o) else $error("driven high");
  a_scl_high_len: assert property (
    @(posedge clock) disable iff (sys_rst) $rose(scl) |-> scl [*8]) else $error("SCL high too short");
  a_start_by_host: assert property (
    @(posedge clock) disable iff (sys_rst) $fell(sda) && scl |-> host_sda_oe) else $error("start not by host");
endmodule : osd_link_checker

//--- verif/tb_top.sv
// Bench joining the microcontroller end and the OSD device end.
`timescale 1ns/1ps
module tb_top;
  import osd_effects_pkg::*;
  logic clock = 0, link_clk = 0, sys_rst = 1, frame_start = 0, win1_on = 0, transp_line = 0, pix_valid = 1;
  logic cmd_valid = 0, cmd_read = 0, cmd_ready, rsp_valid, rsp_err, pix_win2 = 0, osd_valid, osd_show, video_half;
  logic [15:0] cmd_addr = 0;
  logic [9:0]  wdim = 10'h00a, pix_x = 0, pix_y = 0, fl = 0;
  logic [7:0]  pix_nbr = 0;
  logic [5:0]  blink_frames = 0;
  logic [3:0]  pix_attr = 0;
  byte_t       cmd_wdata = 0, rsp_rdata;
  byte_t       pal [6] = '{8'h11, 8'h01, 8'h22, 8'h00, 8'h33, 8'h01};
  color_t      pix_color = 9'h0aa, pix_bg = 9'h055, osd_rgb, c0;
  int          n_mismatch = 0, cmp_count = 0, wait_cnt = 0;
  osd_link_if lnk ();
  always #4 clock = ~clock;
  always #7.5 link_clk = ~link_clk;
  osd_link_master #(.QUARTER_CYC(8)) osd_link_master_i (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .lnk(lnk.host));
  osd_effects_i2c_port osd_effects_i2c_port_i (.clock(clock), .sys_rst(sys_rst), .link_clk(link_clk),
    .lnk(lnk.device), .frame_start(frame_start), .win1_on(win1_on), .win1_width(wdim), .win1_height(wdim),
    .transp_line(transp_line), .blink_frames(blink_frames), .pix_valid(pix_valid), .pix_win2(pix_win2),
    .pix_x(pix_x), .pix_y(pix_y), .pix_color(pix_color), .pix_bg(pix_bg), .pix_attr(pix_attr),
    .pix_two_color(fl[9]), .pix_fg(fl[8]), .pix_nbr(pix_nbr), .pix_box_top(fl[7]), .pix_box_left(fl[6]),
    .pix_box_raised(fl[5]), .pix_box_depressed(fl[4]), .pix_box_heavy(fl[3]), .pix_shadow_en(fl[2]),
    .pix_border_en(fl[1]), .pix_blink_en(fl[0]), .osd_valid(osd_valid), .osd_show(osd_show),
    .osd_rgb(osd_rgb), .video_half(video_half));
  osd_link_checker osd_link_checker_i (.clock(clock), .sys_rst(sys_rst), .link_clk(link_clk),
    .host_scl_o(lnk.host_scl_o), .host_scl_oe(lnk.host_scl_oe), .host_sda_o(lnk.host_sda_o),
    .host_sda_oe(lnk.host_sda_oe), .dev_sda_o(lnk.dev_sda_o), .dev_sda_oe(lnk.dev_sda_oe),
    .scl(lnk.scl), .sda(lnk.sda));
  task automatic final_report();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clock);
    #1;
    wait_cnt += n;
  endtask : tick
  task automatic frame(input int n);
    repeat (n) begin
      frame_start = 1;
      tick();
      frame_start = 0;
      tick();
    end
  endtask : frame
  // One byte per command; a read compares against d.
  task automatic xfer(input logic rd, input logic [15:0] a, input byte_t d);
    wait_cnt = 0;
    cmd_valid = 1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1 && wait_cnt < 3000) tick();
    tick();
    cmd_valid = 0;
    while (rsp_valid !== 1'b1 && wait_cnt < 3000) tick();
    if (wait_cnt >= 3000) begin
      n_mismatch++;
      final_report();
    end
    check(rsp_err, 0);
    if (rd) check(rsp_rdata, d);
  endtask : xfer
  task automatic px(input logic [9:0] f, input logic [7:0] nb, input logic [9:0] x, input logic [9:0] y,
                    input logic sh, input color_t rgb);
    fl = f;
    pix_nbr = nb;
    pix_x = x;
    pix_y = y;
    tick();
    check(osd_valid, pix_valid);
    check(osd_show, sh);
    if (sh) check(osd_rgb, rgb);
  endtask : px
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    xfer(1, 16'h8400, 8'h00);
    xfer(1, 16'h8401, 8'h00);
    for (int k = 0; k < 6; k++) xfer(0, 16'h8405 + 16'(k), pal[k]);
    xfer(0, 16'h8400, 8'h80);
    xfer(1, 16'h8406, 8'h01);
    xfer(1, 16'h840a, 8'h01);
    xfer(1, 16'h8400, 8'h80);
  endtask : t_regs
  task automatic t_fade();
    xfer(0, 16'h8429, 8'h21);
    xfer(0, 16'h8400, 8'ha0);
    win1_on = 1;
    frame(1);
    px(0, 0, 1, 0, 1, 9'h0aa);
    px(0, 0, 2, 0, 0, 0);
    px(0, 0, 0, 1, 0, 0);
    pix_win2 = 1;
    px(0, 0, 5, 5, 1, 9'h0aa);
    pix_win2 = 0;
    frame(4);
    px(0, 0, 9, 4, 1, 9'h0aa);
    px(0, 0, 0, 5, 0, 0);
    xfer(0, 16'h8429, 8'h20);
    frame(1);
    px(0, 0, 0, 9, 1, 9'h0aa);
    // Fade out one step: width shrinks by two, height stays full.
    win1_on = 0;
    frame(1);
    px(0, 0, 7, 9, 1, 9'h0aa);
    px(0, 0, 8, 9, 0, 0);
    win1_on = 1;
    xfer(0, 16'h8400, 8'h80);
    frame(1);
  endtask : t_fade
  task automatic t_fx();
    px(10'h0a0, 0, 0, 0, 1, 9'h111);
    px(10'h050, 0, 0, 0, 1, 9'h022);
    px(10'h098, 0, 0, 0, 1, 9'h133);
    px(10'h204, 8'h02, 3, 3, 1, 9'h133);
    px(10'h204, 8'h10, 3, 3, 1, 9'h0aa);
    px(10'h202, 8'h10, 3, 3, 1, 9'h133);
  endtask : t_fx
  task automatic t_transp();
    pix_color = 0;
    transp_line = 1;
    pix_attr = 7;
    px(0, 0, 0, 0, 0, 0);
    check(video_half, 1);
    pix_valid = 0;
    px(0, 0, 0, 0, 0, 0);
    check(video_half, 0);
    pix_valid = 1;
    transp_line = 0;
    px(0, 0, 0, 0, 1, 0);
    check(video_half, 0);
    transp_line = 1;
    pix_attr = 8;
    px(0, 0, 0, 0, 1, 0);
    check(video_half, 0);
    xfer(0, 16'h8400, 8'h00);
    pix_attr = 0;
    px(0, 0, 0, 0, 0, 0);
    check(video_half, 0);
    transp_line = 0;
    pix_color = 9'h0aa;
  endtask : t_transp
  task automatic t_blink();
    fl = 10'h001;
    tick();
    c0 = osd_rgb;
    frame(1);
    check(c0 ^ osd_rgb, 9'h0ff);
    px(10'h0a1, 0, 0, 0, 1, 9'h111);
    frame(1);
    px(10'h0a1, 0, 0, 0, 1, 9'h111);
    // A slower rate holds the colour for two scans per phase.
    blink_frames = 1;
    fl = 10'h001;
    tick();
    c0 = osd_rgb;
    frame(1);
    check(c0 ^ osd_rgb, 9'h000);
    frame(1);
    check(c0 ^ osd_rgb, 9'h0ff);
  endtask : t_blink
  initial begin
    tick(8);
    sys_rst = 0;
    tick(4);
    t_regs();
    t_fade();
    t_fx();
    t_transp();
    t_blink();
    final_report();
  end
endmodule : tb_top
